// ==== cal_ctl_regs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef CAL_CTL_REGS_SVH
`define CAL_CTL_REGS_SVH
`define BASE_BLOCKING       12'h200
`define BASE_NONBLOCKING    12'h300
`define OFF_CAL_CONTROL     12'h0A0
`define OFF_CAL_STATUS      12'h0A2
`define POS_REF_SEL_MASK_HI 15
`define POS_REF_SEL_MASK_LO 14
`define POS_SHORT_MASK      13
`define POS_OCAL_MASK       12
`define POS_VDIAG_MASK      11
`define POS_IDIAG_MASK      10
`define POS_IRQEN_MASK      8
`define POS_REF_SEL_HI      7
`define POS_REF_SEL_LO      6
`define POS_SHORT           5
`define POS_OCAL            4
`define POS_VDIAG           3
`define POS_IDIAG           2
`define POS_IRQEN           0
`define POS_REF_SET_FLAG    6
`define POS_OCAL_DONE_FLAG  4
`define POS_CAL_REQ_FLAG    0
`define RST_REF_SEL         2'h2
`define OCAL_TIME_NS        2000
`define CLK_PERIOD_NS       20
`define OCAL_CYCLES         (`OCAL_TIME_NS / `CLK_PERIOD_NS)
`define REF_SETTLE_CYCLES   4
`endif

// ==== cal_ctl_pkg.sv ====
// types shared by the calibration control block
package cal_ctl_pkg;
  typedef enum logic [1:0] {REF_OFF, REF_FIRST, REF_SECOND, REF_THIRD} ref_sel_t;
  typedef enum logic [1:0] {OCAL_IDLE, OCAL_RUN, OCAL_HOLD} ocal_state_t;
endpackage : cal_ctl_pkg

// ==== settle_timer.sv ====
// down-counter that pulses done after a programmed number of cycles
module settle_timer #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         run_r;
  logic         run_nxt;
  logic         done_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (start)
    begin
      cnt_nxt = count;
      run_nxt = 1'b1;
    end
    else if (run_r)
    begin
      if (cnt_r <= {{(W-1){1'b0}}, 1'b1})
      begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done  <= done_nxt;
    end
  end
endmodule : settle_timer

// ==== measurement_calibration_control.sv ====
// calibration control and status registers of the measurement front end
`include "cal_ctl_regs.svh"
module measurement_calibration_control (
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  input  wire logic [11:0]           addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic      [15:0]           rdata,
  input  wire logic                  temp_out_of_range,
  output cal_ctl_pkg::ref_sel_t      reference_select,
  output logic                       amp_input_short,
  output logic                       offset_cal_run,
  output logic                       voltage_diag_route,
  output logic                       current_diag_route,
  output logic                       cal_irq
);
  import cal_ctl_pkg::*;

  localparam logic [7:0] OCAL_CNT   = 8'(`OCAL_CYCLES);
  localparam logic [7:0] SETTLE_CNT = 8'(`REF_SETTLE_CYCLES);

  ref_sel_t    ref_sel_r;
  ref_sel_t    ref_sel_nxt;
  logic        short_r;
  logic        short_nxt;
  logic        ocal_r;
  logic        ocal_nxt;
  logic        vdiag_r;
  logic        vdiag_nxt;
  logic        idiag_r;
  logic        idiag_nxt;
  logic        irqen_r;
  logic        irqen_nxt;
  logic        ref_flag_r;
  logic        ref_flag_nxt;
  logic        done_flag_r;
  logic        done_flag_nxt;
  logic        req_flag_r;
  logic        req_flag_nxt;
  ocal_state_t ost_r;
  ocal_state_t ost_nxt;
  logic [15:0] rdata_nxt;
  logic [11:0] offs;
  logic        in_range;
  logic        hit_ctl;
  logic        hit_sr;
  logic        ctl_wr;
  logic        sr_wr;
  logic        tmr_start;
  logic [7:0]  tmr_count;
  logic        tmr_done;
  logic        ref_pending_r;
  logic        ref_pending_nxt;
  logic        ocal_timing;
  logic        settle_run_r;
  logic        settle_run_nxt;

  // both windows map the same registers
  always_comb
  begin
    offs     = '0;
    in_range = 1'b0;
    if (addr >= `BASE_NONBLOCKING && addr < `BASE_NONBLOCKING + 12'h100)
    begin
      offs     = addr - `BASE_NONBLOCKING;
      in_range = 1'b1;
    end
    else if (addr >= `BASE_BLOCKING && addr < `BASE_BLOCKING + 12'h100)
    begin
      offs     = addr - `BASE_BLOCKING;
      in_range = 1'b1;
    end
  end

  assign hit_ctl = in_range && (offs == `OFF_CAL_CONTROL);
  assign hit_sr  = in_range && (offs == `OFF_CAL_STATUS);
  assign ctl_wr  = wr_en && hit_ctl;
  assign sr_wr   = wr_en && hit_sr;

  // one timer is shared: offset calibration and reference settling never overlap in use
  assign ocal_timing = (ost_r == OCAL_RUN);

  always_comb
  begin
    ref_sel_nxt     = ref_sel_r;
    short_nxt       = short_r;
    ocal_nxt        = ocal_r;
    vdiag_nxt       = vdiag_r;
    idiag_nxt       = idiag_r;
    irqen_nxt       = irqen_r;
    ost_nxt         = ost_r;
    ref_pending_nxt = ref_pending_r;
    settle_run_nxt  = settle_run_r;
    tmr_start       = 1'b0;
    tmr_count       = SETTLE_CNT;
    if (ctl_wr)
    begin
      if (wdata[`POS_REF_SEL_MASK_HI] && wdata[`POS_REF_SEL_MASK_LO])
      begin
        ref_sel_nxt     = ref_sel_t'(wdata[`POS_REF_SEL_HI:`POS_REF_SEL_LO]);
        ref_pending_nxt = 1'b1;
      end
      if (wdata[`POS_SHORT_MASK])
        short_nxt = wdata[`POS_SHORT];
      if (wdata[`POS_OCAL_MASK])
        ocal_nxt = wdata[`POS_OCAL];
      if (wdata[`POS_VDIAG_MASK])
        vdiag_nxt = wdata[`POS_VDIAG];
      if (wdata[`POS_IDIAG_MASK])
        idiag_nxt = wdata[`POS_IDIAG];
      if (wdata[`POS_IRQEN_MASK])
        irqen_nxt = wdata[`POS_IRQEN];
    end
    if (tmr_done)
      settle_run_nxt = 1'b0;
    case (ost_r)
      OCAL_IDLE:
        // only a fresh rise of the start bit launches a run
        if (ocal_nxt && !ocal_r)
        begin
          ost_nxt   = OCAL_RUN;
          tmr_start = 1'b1;
          tmr_count = OCAL_CNT;
          // a settle cut short by the run is queued again, else its flag is lost
          if (settle_run_r && !tmr_done)
          begin
            ref_pending_nxt = 1'b1;
            settle_run_nxt  = 1'b0;
          end
        end
      OCAL_RUN:
        if (tmr_done)
          ost_nxt = OCAL_HOLD;
      OCAL_HOLD:
        if (!ocal_r)
          ost_nxt = OCAL_IDLE;
      default:
        ost_nxt = OCAL_IDLE;
    endcase
    if (ref_pending_r && !ocal_timing && !tmr_start)
    begin
      tmr_start       = 1'b1;
      tmr_count       = SETTLE_CNT;
      ref_pending_nxt = ref_sel_nxt != ref_sel_r;
      settle_run_nxt  = 1'b1;
    end
  end

  settle_timer #(
    .W(8)
  ) u_timer (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .start   (tmr_start),
    .count   (tmr_count),
    .done    (tmr_done)
  );

  // set beats a simultaneous write-one clear
  always_comb
  begin
    ref_flag_nxt  = ref_flag_r;
    done_flag_nxt = done_flag_r;
    req_flag_nxt  = req_flag_r;
    if (sr_wr)
    begin
      if (wdata[`POS_REF_SET_FLAG])
        ref_flag_nxt = 1'b0;
      if (wdata[`POS_OCAL_DONE_FLAG])
        done_flag_nxt = 1'b0;
      if (wdata[`POS_CAL_REQ_FLAG])
        req_flag_nxt = 1'b0;
    end
    if (tmr_done && ocal_timing)
      done_flag_nxt = 1'b1;
    if (tmr_done && settle_run_r && ref_sel_r != REF_OFF)
      ref_flag_nxt = 1'b1;
    if (temp_out_of_range)
      req_flag_nxt = 1'b1;
  end

  always_comb
  begin
    rdata_nxt = '0;
    if (rd_en && hit_ctl)
    begin
      rdata_nxt[`POS_REF_SEL_HI:`POS_REF_SEL_LO] = ref_sel_r;
      rdata_nxt[`POS_SHORT] = short_r;
      rdata_nxt[`POS_OCAL]  = ocal_r;
      rdata_nxt[`POS_VDIAG] = vdiag_r;
      rdata_nxt[`POS_IDIAG] = idiag_r;
      rdata_nxt[`POS_IRQEN] = irqen_r;
    end
    else if (rd_en && hit_sr)
    begin
      rdata_nxt[`POS_REF_SET_FLAG]   = ref_flag_r;
      rdata_nxt[`POS_OCAL_DONE_FLAG] = done_flag_r;
      rdata_nxt[`POS_CAL_REQ_FLAG]   = req_flag_r;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_sel_r     <= REF_SECOND;
      short_r       <= 1'b0;
      ocal_r        <= 1'b0;
      vdiag_r       <= 1'b0;
      idiag_r       <= 1'b0;
      irqen_r       <= 1'b0;
      ost_r         <= OCAL_IDLE;
      ref_pending_r <= 1'b1;
      settle_run_r  <= 1'b0;
      ref_flag_r    <= 1'b0;
      done_flag_r   <= 1'b0;
      req_flag_r    <= 1'b0;
      rdata         <= '0;
    end
    else
    begin
      ref_sel_r     <= ref_sel_nxt;
      short_r       <= short_nxt;
      ocal_r        <= ocal_nxt;
      vdiag_r       <= vdiag_nxt;
      idiag_r       <= idiag_nxt;
      irqen_r       <= irqen_nxt;
      ost_r         <= ost_nxt;
      ref_pending_r <= ref_pending_nxt;
      settle_run_r  <= settle_run_nxt;
      ref_flag_r    <= ref_flag_nxt;
      done_flag_r   <= done_flag_nxt;
      req_flag_r    <= req_flag_nxt;
      rdata         <= rdata_nxt;
    end
  end

  assign reference_select   = ref_sel_r;
  assign amp_input_short    = short_r;
  assign offset_cal_run     = ocal_timing;
  assign voltage_diag_route = vdiag_r;
  assign current_diag_route = idiag_r;
  assign cal_irq            = req_flag_r && irqen_r;

  masked_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ctl_wr && !wdata[`POS_SHORT_MASK] |=> $stable(short_r))
    else $error("input short changed without its mask");
  ocal_mask_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ctl_wr && !wdata[`POS_OCAL_MASK] |=> $stable(ocal_r))
    else $error("offset start changed without its mask");
  ref_mask_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ctl_wr && wdata[15:14] == 2'h3 |=> ref_sel_r == $past(wdata[7:6]))
    else $error("reference select not taken under mask");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ctl_wr && wdata[`POS_IRQEN_MASK] && !wdata[`POS_IRQEN] |=> !cal_irq)
    else $error("interrupt not gated by enable");
  req_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    temp_out_of_range |=> req_flag_r)
    else $error("request flag lost on out-of-range");
  fresh_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ost_r == OCAL_HOLD && ocal_r |=> ost_r != OCAL_RUN)
    else $error("calibration restarted without fresh start");
  done_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ost_r == OCAL_RUN && tmr_done |=> done_flag_r && ost_r == OCAL_HOLD)
    else $error("done flag not set at completion");
  w1c_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sr_wr && wdata[0] && !temp_out_of_range |=> !req_flag_r)
    else $error("request flag not cleared by write one");
  mask_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rd_en |=> rdata[15:8] == 8'h00)
    else $error("mask bits read non-zero");
  read_stands_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rd_en ##1 !rd_en |=> rdata == 16'h0000)
    else $error("read data outlived its cycle");
  vdiag_mask_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ctl_wr && wdata[11] |=> voltage_diag_route == $past(wdata[3]))
    else $error("voltage diag not written under mask");
  idiag_mask_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ctl_wr && wdata[10] |=> current_diag_route == $past(wdata[2]))
    else $error("current diag not written under mask");
  irqen_mask_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ctl_wr && !wdata[8] |=> $stable(irqen_r))
    else $error("irq enable changed without its mask");
endmodule : measurement_calibration_control

// ==== measurement_calibration_control_tb.sv ====
// self-checking bench for the calibration control registers
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module measurement_calibration_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cal_ctl_pkg::*;
  logic                 sys_clk;
  logic                 arst_n;
  logic [11:0]          addr;
  logic [15:0]          wdata;
  logic                 wr_en;
  logic                 rd_en;
  logic [15:0]          rdata;
  logic                 temp_out_of_range;
  ref_sel_t             reference_select;
  logic                 amp_input_short;
  logic                 offset_cal_run;
  logic                 voltage_diag_route;
  logic                 current_diag_route;
  logic                 cal_irq;
  logic [15:0]          rv;
  logic [15:0]          w;
  logic [7:0]           ex;
  logic [15:0]          corner [3];
  integer               seed;
  int                   errors;
  int                   compares;

  measurement_calibration_control dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .temp_out_of_range(temp_out_of_range), .reference_select(reference_select),
    .amp_input_short(amp_input_short), .offset_cal_run(offset_cal_run),
    .voltage_diag_route(voltage_diag_route), .current_diag_route(current_diag_route),
    .cal_irq(cal_irq)
  );

  always #10 sys_clk = ~sys_clk;

  // masked update of the stored control byte
  function automatic logic [7:0] ctl_nxt(input logic [7:0] o, input logic [15:0] d);
    logic [7:0] n;
    n = o;
    if (d[15] && d[14]) n[7:6] = d[7:6];
    if (d[13]) n[5] = d[5];
    if (d[12]) n[4] = d[4];
    if (d[11]) n[3] = d[3];
    if (d[10]) n[2] = d[2];
    if (d[8]) n[0] = d[0];
    return n;
  endfunction : ctl_nxt

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    rv = rdata;
  endtask : rd

  task automatic stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  initial
  begin
    #400000;
    errors++;
    stop_test();
  end

  initial
  begin
    seed = 65;
    sys_clk = 1'b0;
    arst_n = 1'b0;
    addr = 12'h000;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    temp_out_of_range = 1'b0;
    errors = 0;
    compares = 0;
    ex = 8'h80;
    // masks with zero data, data without masks, half a reference mask
    corner = '{16'hFF00, 16'h00FF, 16'h40C0};
    repeat (4) @(posedge sys_clk);
    `CHK(reference_select, 2'h2)
    `CHK(rdata, 16'h0000)
    arst_n <= 1'b1;
    rd(12'h2A0);
    `CHK(rv, 16'h0080)
    rd(12'h3A2);
    `CHK(rv & 16'hFFBF, 16'h0000)
    for (int i = 0; i < 43; i++)
    begin
      w = (i < 3) ? corner[i] : 16'($random(seed));
      ex = ctl_nxt(ex, w);
      wr(w[1] ? 12'h3A0 : 12'h2A0, w);
      `CHK(reference_select, ex[7:6])
      `CHK(amp_input_short, ex[5])
      `CHK(voltage_diag_route, ex[3])
      `CHK(current_diag_route, ex[2])
      rd(w[1] ? 12'h2A0 : 12'h3A0);
      `CHK(rv, {8'h00, ex})
    end
    // unmapped place: ignored write, zero read
    wr(12'h2A4, 16'hFFFF);
    rd(12'h2A0);
    `CHK(rv, {8'h00, ex})
    rd(12'h2A4);
    `CHK(rv, 16'h0000)
    // drop the start bit, let any run finish, then start fresh
    wr(12'h2A0, 16'h1000);
    repeat (110) @(posedge sys_clk);
    // short stays on for the whole run; current channel lives outside
    wr(12'h2A0, 16'h3030);
    `CHK(offset_cal_run, 1'b1)
    `CHK(amp_input_short, 1'b1)
    repeat (95) @(posedge sys_clk);
    #1;
    `CHK(offset_cal_run, 1'b1)
    repeat (10) @(posedge sys_clk);
    #1;
    `CHK(offset_cal_run, 1'b0)
    `CHK(amp_input_short, 1'b1)
    rd(12'h2A2);
    `CHK(rv[4], 1'b1)
    wr(12'h2A2, 16'h0010);
    rd(12'h2A2);
    `CHK(rv[4], 1'b0)
    // start bit still set: no fresh rising, no new run
    wr(12'h2A0, 16'h1010);
    `CHK(offset_cal_run, 1'b0)
    wr(12'h2A2, 16'h0040);
    wr(12'h2A0, 16'hC040);
    `CHK(reference_select, 2'h1)
    repeat (10) @(posedge sys_clk);
    rd(12'h2A2);
    `CHK(rv[6], 1'b1)
    wr(12'h2A0, 16'h0101);
    @(posedge sys_clk);
    temp_out_of_range <= 1'b1;
    @(posedge sys_clk);
    temp_out_of_range <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(cal_irq, 1'b1)
    rd(12'h3A2);
    `CHK(rv[0], 1'b1)
    wr(12'h2A0, 16'h0100);
    `CHK(cal_irq, 1'b0)
    wr(12'h2A0, 16'h0101);
    `CHK(cal_irq, 1'b1)
    wr(12'h2A2, 16'h0001);
    `CHK(cal_irq, 1'b0)
    // out-of-range in the very cycle of its clear: the set wins
    @(posedge sys_clk);
    addr <= 12'h2A2;
    wdata <= 16'h0001;
    wr_en <= 1'b1;
    temp_out_of_range <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    temp_out_of_range <= 1'b0;
    #1;
    `CHK(cal_irq, 1'b1)
    rd(12'h2A2);
    `CHK(rv[0], 1'b1)
    stop_test();
  end
endmodule : measurement_calibration_control_tb
